// *** core/light_prox_alert.sv ***
// register file, proximity/light alert logic, emitter duty and alert pin
`timescale 1ns/1ps
`default_nettype none
module light_prox_alert
  import light_prox_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h60,
  parameter logic [15:0] ID_WORD = 16'h0000, // arbitrary identification value
  parameter int EMIT_DIV = EMIT_SLOT_CYC,
  parameter int DW = 16
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // alert pin, open drain
  output logic alert_o,
  output logic alert_oe_o,
  // emitter and measurement front end
  output logic emitter_drive_pin_o,
  output logic prox_measure_o,
  input wire logic prox_raw_valid_i,
  input wire logic [DW-1:0] prox_raw_i,
  input wire logic sunlight_i,
  // light front end
  input wire logic light_valid_i,
  input wire logic [DW-1:0] light_raw_i,
  output logic light_enable_o,
  output logic [9:0] light_integration_ms_o,
  output logic [1:0] light_range_shift_o
);
  light_prox_link_if link ();

  serial_byte_engine #(.DEV_ADDR(DEV_ADDR)) u_engine (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .link(link.engine)
  );

  logic [15:0] regs_q [RW_REGS];
  logic [7:0] cmd_q, flags_q, snap_q, flag_set, flag_clr;
  logic first_q, hi_q;
  logic [15:0] prox_res_q, light_res_q, prox_res_d, rd_word;
  logic [15:0] light_hi, light_lo, prox_hi, prox_lo, xtalk;
  logic [1:0] prox_pers, prox_trig, duty;
  logic [2:0] light_pers_max;
  logic [2:0] pa_cnt_q, pd_cnt_q, la_cnt_q, lb_cnt_q;
  logic near_q, presence, forced, shot, prox_on, light_en;
  logic [$clog2(EMIT_DIV+1)-1:0] div_q;
  logic tick_q;
  logic [8:0] slot_q, ratio;
  logic periodic_go, forced_go;
  logic prox_above, prox_below, light_above, light_below;

  assign light_hi = regs_q[CMD_LIGHT_HI[2:0]];
  assign light_lo = regs_q[CMD_LIGHT_LO[2:0]];
  assign prox_lo = regs_q[CMD_PROX_LO[2:0]];
  assign prox_hi = regs_q[CMD_PROX_HI[2:0]];
  assign xtalk = regs_q[CMD_XTALK[2:0]];
  assign duty = regs_q[CMD_PROX_CONF[2:0]][PX_DUTY_LSB +: 2];
  assign prox_pers = regs_q[CMD_PROX_CONF[2:0]][PX_PERS_LSB +: 2];
  assign prox_on = ~regs_q[CMD_PROX_CONF[2:0]][PX_SD_BIT];
  assign prox_trig = regs_q[CMD_PROX_CONF[2:0]][PX_TRIG_LSB +: 2];
  assign forced = regs_q[CMD_PROX_MODE[2:0]][PM_FORCED_BIT];
  assign shot = regs_q[CMD_PROX_MODE[2:0]][PM_SHOT_BIT];
  assign presence = regs_q[CMD_PROX_MODE[2:0]][PM_PRESENCE_BIT];
  assign light_en = regs_q[CMD_LIGHT_CONF[2:0]][LT_EN_BIT];
  assign light_pers_max = 3'(({1'b0, 2'h1} << regs_q[CMD_LIGHT_CONF[2:0]][LT_PERS_LSB +: 2]) - 3'h1);

  // register writes: command byte, then low byte, then high byte
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < RW_REGS; i++) begin
        regs_q[i] <= reg_reset(i);
      end
      cmd_q <= 8'h00;
      first_q <= 1'b1;
      hi_q <= 1'b0;
    end else begin
      if (link.start) begin
        first_q <= 1'b1;
        hi_q <= 1'b0;
      end else if (link.wr_pulse && first_q) begin
        cmd_q <= link.wr_data;
        first_q <= 1'b0;
        hi_q <= 1'b0;
      end else if (link.wr_pulse || link.rd_done) begin
        hi_q <= ~hi_q;
      end
      // writes land even while the alert pin is held low
      if (link.wr_pulse && !first_q && cmd_q < 8'(RW_REGS)) begin
        if (hi_q) begin
          regs_q[cmd_q[2:0]][15:8] <= link.wr_data;
        end else begin
          regs_q[cmd_q[2:0]][7:0] <= link.wr_data;
        end
      end
      // a trigger byte written in the issue cycle is a fresh request and wins
      if (forced_go && !(link.wr_pulse && !first_q && !hi_q && cmd_q == CMD_PROX_MODE)) begin
        regs_q[CMD_PROX_MODE[2:0]][PM_SHOT_BIT] <= 1'b0;
      end
    end
  end

  // read path: every code answers, unused codes read zero
  always_comb begin
    rd_word = 16'h0000;
    if (cmd_q < 8'(RW_REGS)) begin
      rd_word = regs_q[cmd_q[2:0]];
    end else begin
      case (cmd_q)
        CMD_PROX_RES: rd_word = prox_res_q;
        CMD_LIGHT_RES: rd_word = light_res_q;
        CMD_FLAGS: rd_word = {flags_q, 8'h00};
        CMD_ID: rd_word = ID_WORD;
        default: rd_word = 16'h0000;
      endcase
    end
  end
  assign link.rd_data = hi_q ? rd_word[15:8] : rd_word[7:0];

  // emitter slot divider and duty period
  assign ratio = EMIT_RATIO_BASE << duty;
  assign periodic_go = tick_q && slot_q == 9'h000 && prox_on && !forced;
  assign forced_go = tick_q && forced && shot;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_q <= '0;
      tick_q <= 1'b0;
      slot_q <= 9'h000;
      emitter_drive_pin_o <= 1'b0;
      prox_measure_o <= 1'b0;
    end else begin
      tick_q <= (div_q == $bits(div_q)'(EMIT_DIV - 1));
      div_q <= (div_q == $bits(div_q)'(EMIT_DIV - 1)) ? '0 : div_q + 1'b1;
      if (tick_q) begin
        slot_q <= (slot_q >= ratio - 9'h001) ? 9'h000 : slot_q + 9'h001;
      end
      prox_measure_o <= periodic_go || forced_go;
      // emitter lit for one slot per measurement, so average current scales with duty
      if (periodic_go || forced_go) begin
        emitter_drive_pin_o <= 1'b1;
      end else if (tick_q) begin
        emitter_drive_pin_o <= 1'b0;
      end
    end
  end

  // proximity result with crosstalk removed, clamped at zero
  assign prox_res_d = (prox_raw_i > xtalk) ? prox_raw_i - xtalk : 16'h0000;
  assign prox_above = prox_res_d > prox_hi;
  assign prox_below = prox_res_d < prox_lo;
  assign light_above = light_raw_i > light_hi;
  assign light_below = light_raw_i < light_lo;

  // proximity persistence and approach/departure state
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prox_res_q <= 16'h0000;
      pa_cnt_q <= 3'h0;
      pd_cnt_q <= 3'h0;
      near_q <= 1'b0;
    end else if (prox_raw_valid_i) begin
      prox_res_q <= prox_res_d;
      pa_cnt_q <= 3'h0;
      pd_cnt_q <= 3'h0;
      if (prox_above) begin
        if (pa_cnt_q >= {1'b0, prox_pers}) begin
          near_q <= 1'b1;
          pa_cnt_q <= pa_cnt_q;
        end else begin
          pa_cnt_q <= pa_cnt_q + 3'h1;
        end
      end else if (prox_below) begin
        if (pd_cnt_q >= {1'b0, prox_pers}) begin
          near_q <= 1'b0;
          pd_cnt_q <= pd_cnt_q;
        end else begin
          pd_cnt_q <= pd_cnt_q + 3'h1;
        end
      end
    end
  end

  // light persistence counters and stored result
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      light_res_q <= 16'h0000;
      la_cnt_q <= 3'h0;
      lb_cnt_q <= 3'h0;
    end else if (light_valid_i) begin
      light_res_q <= light_raw_i;
      la_cnt_q <= !light_above ? 3'h0 : (la_cnt_q >= light_pers_max) ? la_cnt_q : la_cnt_q + 3'h1;
      lb_cnt_q <= !light_below ? 3'h0 : (lb_cnt_q >= light_pers_max) ? lb_cnt_q : lb_cnt_q + 3'h1;
    end
  end

  // flag events; approach/departure flags on transitions only, light flags on every qualifying sample; a result inside the window keeps quiet
  always_comb begin
    flag_set = 8'h00;
    if (prox_raw_valid_i && prox_above && !near_q && pa_cnt_q >= {1'b0, prox_pers}) begin
      flag_set[FL_APPR] = prox_trig[0];
    end
    if (prox_raw_valid_i && prox_below && near_q && pd_cnt_q >= {1'b0, prox_pers}) begin
      flag_set[FL_DEP] = prox_trig[1];
    end
    if (light_valid_i && light_en) begin
      flag_set[FL_ABOVE] = light_above && la_cnt_q >= light_pers_max;
      flag_set[FL_BELOW] = light_below && lb_cnt_q >= light_pers_max;
    end
    flag_set[FL_SUN] = sunlight_i && (prox_trig != 2'h0);
  end

  assign flag_clr = (link.rd_done && cmd_q == CMD_FLAGS && hi_q) ? snap_q : 8'h00;

  // clear after the byte went out; a new event in that cycle survives
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flags_q <= 8'h00;
      snap_q <= 8'h00;
    end else begin
      if (link.rd_load) begin
        snap_q <= flags_q;
      end
      flags_q <= ((flags_q & ~flag_clr) | flag_set) & FLAG_MASK;
    end
  end

  // shared pin: flags in normal mode, proximity level in presence mode
  assign alert_o = 1'b0;
  assign alert_oe_o = presence ? near_q : (flags_q != 8'h00);

  // light front-end controls
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      light_enable_o <= 1'b0;
      light_integration_ms_o <= 10'h000;
      light_range_shift_o <= 2'h0;
    end else begin
      light_enable_o <= ~regs_q[CMD_LIGHT_CONF[2:0]][LT_SD_BIT];
      light_integration_ms_o <= light_it_ms(regs_q[CMD_LIGHT_CONF[2:0]][LT_IT_LSB +: 3]);
      light_range_shift_o <= {1'b0, regs_q[CMD_LIGHT_CONF[2:0]][LT_WIDE_BIT]}
                           + {1'b0, regs_q[CMD_LIGHT_CONF[2:0]][LT_HALVE_BIT]};
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  a_duty_start: assert property (periodic_go |=> prox_measure_o && emitter_drive_pin_o)
    else $error("periodic slot did not fire the emitter");
  a_duty_ratio: assert property (tick_q && slot_q == ratio - 9'h001 |=> slot_q == 9'h000)
    else $error("duty period length wrong");
  a_forced_quiet: assert property (forced && $past(forced) && prox_measure_o |-> $past(shot))
    else $error("forced mode measured without trigger");
  a_shot_clear: assert property (forced_go && !link.wr_pulse |=> !shot)
    else $error("trigger bit not cleared after issue");
  a_xtalk_sub: assert property (prox_raw_valid_i |=> prox_res_q ==
    (($past(prox_raw_i) > $past(xtalk)) ? $past(prox_raw_i) - $past(xtalk) : 16'h0000))
    else $error("crosstalk subtraction wrong");
  a_flag_pin: assert property (!presence && flag_set != 8'h00 ##1 !presence |-> alert_oe_o)
    else $error("flag set but pin released");
  a_presence_pin: assert property (presence && prox_raw_valid_i && prox_above && pa_cnt_q >= {1'b0, prox_pers}
    ##1 presence |-> alert_oe_o)
    else $error("presence pin disagrees with state");
  a_hysteresis: assert property (prox_raw_valid_i && !prox_above && !prox_below |=> $stable(near_q))
    else $error("state moved inside window");
  a_light_restart: assert property (light_valid_i && !light_above |=> la_cnt_q == 3'h0)
    else $error("light counter not restarted");
  a_clear_read: assert property (flag_clr != 8'h00 && flag_set == 8'h00 |=> (flags_q & $past(flag_clr)) == 8'h00)
    else $error("flag read did not clear");

  c_approach: cover property (flag_set[FL_APPR] ##[1:200] alert_oe_o);
  c_flag_read: cover property (flag_clr != 8'h00);
  c_forced_shot: cover property (forced_go);
endmodule // light_prox_alert
`default_nettype wire

// *** core/light_prox_link_if.sv ***
// byte-level carrier between the bus engine and the register logic
`timescale 1ns/1ps
`default_nettype none
interface light_prox_link_if;
  logic start;
  logic stop;
  logic wr_pulse;
  logic [7:0] wr_data;
  logic rd_load;
  logic [7:0] rd_data;
  logic rd_done;
  modport engine (output start, output stop, output wr_pulse, output wr_data,
                  output rd_load, output rd_done, input rd_data);
  modport regs (input start, input stop, input wr_pulse, input wr_data,
                input rd_load, input rd_done, output rd_data);
endinterface
`default_nettype wire

// *** core/light_prox_pkg.sv ***
// constants, register map and decode helpers of the light and proximity alert logic
package light_prox_pkg;
  localparam int CLK_HZ = 10_000_000;
  // emitter slot length and its cycle count
  localparam int EMIT_SLOT_NS = 1000;
  localparam int EMIT_SLOT_CYC = (EMIT_SLOT_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam logic [8:0] EMIT_RATIO_BASE = 9'h028;
  // command codes
  localparam logic [7:0] CMD_LIGHT_CONF = 8'h00;
  localparam logic [7:0] CMD_LIGHT_HI = 8'h01;
  localparam logic [7:0] CMD_LIGHT_LO = 8'h02;
  localparam logic [7:0] CMD_PROX_CONF = 8'h03;
  localparam logic [7:0] CMD_PROX_MODE = 8'h04;
  localparam logic [7:0] CMD_XTALK = 8'h05;
  localparam logic [7:0] CMD_PROX_LO = 8'h06;
  localparam logic [7:0] CMD_PROX_HI = 8'h07;
  localparam logic [7:0] CMD_PROX_RES = 8'h08;
  localparam logic [7:0] CMD_LIGHT_RES = 8'h0b;
  localparam logic [7:0] CMD_FLAGS = 8'h0d;
  localparam logic [7:0] CMD_ID = 8'h0e;
  localparam int RW_REGS = 8;
  localparam logic [15:0] LIGHT_CONF_RST = 16'h0101;
  localparam logic [15:0] PROX_CONF_RST = 16'h0001;
  localparam logic [15:0] ZERO_RST = 16'h0000;
  // field positions inside the 16-bit words; flag positions inside the 8-bit flag byte
  localparam int LT_IT_LSB = 5;
  localparam int LT_WIDE_BIT = 4;
  localparam int LT_PERS_LSB = 2;
  localparam int LT_EN_BIT = 1;
  localparam int LT_SD_BIT = 0;
  localparam int LT_HALVE_BIT = 9;
  localparam int PX_DUTY_LSB = 6;
  localparam int PX_PERS_LSB = 4;
  localparam int PX_SD_BIT = 0;
  localparam int PX_TRIG_LSB = 8;
  localparam int PM_FORCED_BIT = 3;
  localparam int PM_SHOT_BIT = 2;
  localparam int PM_PRESENCE_BIT = 1;
  localparam int FL_BELOW = 5;
  localparam int FL_ABOVE = 4;
  localparam int FL_SUN = 2;
  localparam int FL_APPR = 1;
  localparam int FL_DEP = 0;
  localparam logic [7:0] FLAG_MASK = 8'h37;

  function automatic logic [15:0] reg_reset(input int idx);
    case (idx)
      0: reg_reset = LIGHT_CONF_RST;
      3: reg_reset = PROX_CONF_RST;
      default: reg_reset = ZERO_RST;
    endcase
  endfunction

  function automatic logic [9:0] light_it_ms(input logic [2:0] code);
    case (code)
      3'h0: light_it_ms = 10'h032;
      3'h1: light_it_ms = 10'h064;
      3'h2: light_it_ms = 10'h0c8;
      3'h3: light_it_ms = 10'h190;
      default: light_it_ms = 10'h320;
    endcase
  endfunction
endpackage

// *** core/serial_byte_engine.sv ***
// two-wire serial slave: start/stop, address match, byte shift in and out
`timescale 1ns/1ps
`default_nettype none
module serial_byte_engine
  import light_prox_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h60
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // byte side
  light_prox_link_if.engine link
);
  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001, S_ADDR = 7'b0000010, S_AACK = 7'b0000100, S_WR = 7'b0001000,
    S_WACK = 7'b0010000, S_RD = 7'b0100000, S_RACK = 7'b1000000
  } eng_state_t;
  eng_state_t st_q;
  logic [2:0] scl_q, sda_q;
  logic [7:0] sh_q;
  logic [2:0] cnt_q;
  logic full_q, rw_q, nack_q;
  logic rise, fall, start_c, stop_c;

  // first stage feeds only the second one
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], scl_i};
      sda_q <= {sda_q[1:0], sda_i};
    end
  end

  assign rise = scl_q[1] & ~scl_q[2];
  assign fall = ~scl_q[1] & scl_q[2];
  assign start_c = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
  assign stop_c = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
  assign sda_o = 1'b0;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= S_IDLE;
      sh_q <= 8'h00;
      cnt_q <= 3'h0;
      full_q <= 1'b0;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      sda_oe_o <= 1'b0;
      link.start <= 1'b0;
      link.stop <= 1'b0;
      link.wr_pulse <= 1'b0;
      link.wr_data <= 8'h00;
      link.rd_load <= 1'b0;
      link.rd_done <= 1'b0;
    end else begin
      link.start <= start_c;
      link.stop <= stop_c;
      link.wr_pulse <= 1'b0;
      link.rd_load <= 1'b0;
      link.rd_done <= 1'b0;
      if (start_c) begin
        st_q <= S_ADDR;
        cnt_q <= 3'h0;
        full_q <= 1'b0;
        sda_oe_o <= 1'b0;
      end else if (stop_c) begin
        st_q <= S_IDLE;
        sda_oe_o <= 1'b0;
      end else begin
        case (st_q)
          S_ADDR, S_WR: begin
            if (rise) begin
              sh_q <= {sh_q[6:0], sda_q[1]};
              cnt_q <= cnt_q + 3'h1;
              full_q <= (cnt_q == 3'h7);
            end else if (fall && full_q) begin
              full_q <= 1'b0;
              if (st_q == S_WR) begin
                link.wr_pulse <= 1'b1;
                link.wr_data <= sh_q;
                sda_oe_o <= 1'b1;
                st_q <= S_WACK;
              end else if (sh_q[7:1] == DEV_ADDR) begin
                rw_q <= sh_q[0];
                sda_oe_o <= 1'b1;
                st_q <= S_AACK;
              end else begin
                st_q <= S_IDLE;
              end
            end
          end
          S_AACK, S_WACK: begin
            if (fall) begin
              sda_oe_o <= 1'b0;
              cnt_q <= 3'h0;
              st_q <= (st_q == S_AACK && rw_q) ? S_RD : S_WR;
              link.rd_load <= (st_q == S_AACK && rw_q);
            end
          end
          S_RD: begin
            // first bit leaves one cycle after the load request, while the host still holds the clock low
            if (link.rd_load) begin
              sh_q <= link.rd_data;
              sda_oe_o <= ~link.rd_data[7];
            end else if (rise) begin
              cnt_q <= cnt_q + 3'h1;
              full_q <= (cnt_q == 3'h7);
            end else if (fall) begin
              if (full_q) begin
                full_q <= 1'b0;
                sda_oe_o <= 1'b0;
                st_q <= S_RACK;
              end else begin
                sh_q <= {sh_q[6:0], 1'b0};
                sda_oe_o <= ~sh_q[6];
              end
            end
          end
          S_RACK: begin
            if (rise) begin
              nack_q <= sda_q[1];
              link.rd_done <= 1'b1;
            end else if (fall) begin
              cnt_q <= 3'h0;
              st_q <= nack_q ? S_IDLE : S_RD;
              link.rd_load <= ~nack_q;
            end
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end
endmodule // serial_byte_engine
`default_nettype wire

// *** test/bus_host_model.sv ***
// two-wire bus host model that writes and reads register words
`timescale 1ns/1ps
`default_nettype none
module bus_host_model #(
  parameter logic [6:0] ADDR = 7'h60
) (
  // clock
  input wire logic ref_clk_i,
  // bus pins, sda_i is the resolved wire
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // data moves only while the clock is low, so no false start or stop
  task automatic bit_x(input logic b, output logic s);
    sda_low_o <= ~b;
    tk(3);
    scl_o <= 1'b1;
    tk(4);
    s = sda_i;
    scl_o <= 1'b0;
    tk(1);
  endtask
  task automatic start();
    sda_low_o <= 1'b0;
    tk(3);
    scl_o <= 1'b1;
    tk(4);
    sda_low_o <= 1'b1;
    tk(4);
    scl_o <= 1'b0;
    tk(1);
  endtask
  task automatic stop();
    sda_low_o <= 1'b1;
    tk(3);
    scl_o <= 1'b1;
    tk(4);
    sda_low_o <= 1'b0;
    tk(4);
  endtask
  task automatic byte_x(input logic [7:0] b, input logic a, output logic [7:0] r);
    logic n;
    for (int i = 7; i >= 0; i--) begin
      bit_x(b[i], r[i]);
    end
    bit_x(a, n);
  endtask
  // a word goes low byte first, then high byte
  task automatic wr(input logic [7:0] c, input logic [15:0] w);
    logic [7:0] r;
    start();
    byte_x({ADDR, 1'b0}, 1'b1, r);
    byte_x(c, 1'b1, r);
    byte_x(w[7:0], 1'b1, r);
    byte_x(w[15:8], 1'b1, r);
    stop();
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] w);
    logic [7:0] r;
    start();
    byte_x({ADDR, 1'b0}, 1'b1, r);
    byte_x(c, 1'b1, r);
    start();
    byte_x({ADDR, 1'b1}, 1'b1, r);
    byte_x(8'hff, 1'b0, w[7:0]); // word read, low byte acknowledged
    byte_x(8'hff, 1'b1, w[15:8]); // high byte refused to end the word
    stop();
  endtask
endmodule // bus_host_model
`default_nettype wire

// *** test/tb.sv ***
// testbench: registers, light and proximity alerts, forced and emitter timing
`timescale 1ns/1ps
`default_nettype none
module tb;
  import light_prox_pkg::*;
  localparam int DIV = 2;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic scl, host_low, sda_oe, alert_oe, meas, lt_en, emit, alert_v;
  logic pv = 1'b0;
  logic sun = 1'b0;
  logic lv = 1'b0;
  logic [15:0] praw = 16'h0000;
  logic [15:0] lraw = 16'h0000;
  logic [15:0] rd;
  logic [9:0] it_ms;
  logic [1:0] shift;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  int last = 0;
  int per = 0;
  int n_meas = 0;
  int ms[5] = '{50, 100, 200, 400, 800};
  wire logic sda = ~(host_low | sda_oe);
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (meas === 1'b1) begin
      n_meas = n_meas + 1;
      chk("emitter", {15'h0000, emit}, 16'h0001);
      per = cyc - last;
      last = cyc;
    end
  end
  bus_host_model host (.ref_clk_i(ref_clk), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));
  light_prox_alert #(.EMIT_DIV(DIV)) dut (.ref_clk_i(ref_clk), .resetn_i(resetn), .scl_i(scl), .sda_i(sda),
    .sda_o(), .sda_oe_o(sda_oe), .alert_o(alert_v), .alert_oe_o(alert_oe), .emitter_drive_pin_o(emit),
    .prox_measure_o(meas), .prox_raw_valid_i(pv), .prox_raw_i(praw), .sunlight_i(sun), .light_valid_i(lv),
    .light_raw_i(lraw),
    .light_enable_o(lt_en), .light_integration_ms_o(it_ms), .light_range_shift_o(shift));
  task automatic chk(input string s, input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // one front-end sample, proximity when p is set, else light
  task automatic smp(input logic p, input logic [15:0] v);
    praw <= v;
    lraw <= v;
    pv <= p;
    lv <= ~p;
    @(posedge ref_clk);
    pv <= 1'b0;
    lv <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic t_regs();
    chk("it_ms", {6'h00, it_ms}, 16'h0032);
    chk("light off", {15'h0000, lt_en}, 16'h0000);
    chk("alert level", {15'h0000, alert_v}, 16'h0000);
    host.rd(CMD_LIGHT_CONF, rd);
    chk("light conf", rd, 16'h0101);
    host.rd(CMD_PROX_CONF, rd);
    chk("prox conf", rd, 16'h0001);
    host.wr(CMD_LIGHT_HI, 16'ha55a);
    host.rd(CMD_LIGHT_HI, rd);
    chk("light high", rd, 16'ha55a);
    host.rd(8'h09, rd);
    chk("unmapped", rd, 16'h0000);
  endtask
  task automatic t_light_cfg();
    for (int i = 0; i < 8; i++) begin
      host.wr(CMD_LIGHT_CONF, {6'h00, i[1], 1'b0, i[2:0], i[0], 4'h0});
      chk("it_ms", {6'h00, it_ms}, 16'(ms[i > 4 ? 4 : i]));
      chk("shift", {14'h0000, shift}, 16'(i % 2 + i / 2 % 2));
      chk("light on", {15'h0000, lt_en}, 16'h0001);
    end
  endtask
  task automatic t_light_alert();
    host.wr(CMD_LIGHT_HI, 16'd1000);
    host.wr(CMD_LIGHT_LO, 16'd10);
    host.wr(CMD_LIGHT_CONF, 16'h0006);
    smp(1'b0, 16'd2000);
    chk("alert one", {15'h0000, alert_oe}, 16'h0000);
    smp(1'b0, 16'd2000);
    chk("alert two", {15'h0000, alert_oe}, 16'h0001);
    host.rd(CMD_LIGHT_RES, rd);
    chk("light result", rd, 16'd2000);
    host.rd(CMD_FLAGS, rd);
    chk("flags above", rd, 16'h1000);
    chk("alert clear", {15'h0000, alert_oe}, 16'h0000);
    smp(1'b0, 16'd5);
    smp(1'b0, 16'd5);
    host.rd(CMD_FLAGS, rd);
    chk("flags below", rd, 16'h2000);
  endtask
  task automatic t_prox();
    host.wr(CMD_XTALK, 16'd50);
    host.wr(CMD_PROX_LO, 16'd100);
    host.wr(CMD_PROX_HI, 16'd200);
    host.wr(CMD_PROX_CONF, 16'h0310);
    smp(1'b1, 16'd300);
    smp(1'b1, 16'd200);
    smp(1'b1, 16'd300);
    chk("run broken", {15'h0000, alert_oe}, 16'h0000);
    smp(1'b1, 16'd300);
    chk("approach", {15'h0000, alert_oe}, 16'h0001);
    host.rd(CMD_PROX_RES, rd);
    chk("prox result", rd, 16'd250);
    host.rd(CMD_FLAGS, rd);
    chk("flags approach", rd, 16'h0200);
    smp(1'b1, 16'd100);
    smp(1'b1, 16'd100);
    host.rd(CMD_FLAGS, rd);
    chk("flags departure", rd, 16'h0100);
    sun <= 1'b1;
    @(posedge ref_clk);
    sun <= 1'b0;
    host.rd(CMD_FLAGS, rd);
    chk("flags sunlight", rd, 16'h0400);
  endtask
  task automatic t_presence();
    host.wr(CMD_PROX_MODE, 16'h0002);
    smp(1'b1, 16'd300);
    smp(1'b1, 16'd300);
    host.rd(CMD_FLAGS, rd);
    chk("near level", {15'h0000, alert_oe}, 16'h0001);
    smp(1'b1, 16'd100);
    smp(1'b1, 16'd100);
    chk("far level", {15'h0000, alert_oe}, 16'h0000);
    host.wr(CMD_PROX_MODE, 16'h0000);
    chk("normal pin", {15'h0000, alert_oe}, 16'h0001);
    host.rd(CMD_FLAGS, rd);
  endtask
  task automatic t_forced();
    host.wr(CMD_PROX_MODE, 16'h0008);
    n_meas = 0;
    repeat (700) @(posedge ref_clk);
    chk("standby", 16'(n_meas), 16'h0000);
    host.wr(CMD_PROX_MODE, 16'h000c);
    repeat (100) @(posedge ref_clk);
    chk("one shot", 16'(n_meas), 16'h0001);
    host.rd(CMD_PROX_MODE, rd);
    chk("trigger clear", rd, 16'h0008);
    host.wr(CMD_PROX_MODE, 16'h0000);
  endtask
  // the first period after a change may be mixed, so the second is judged
  task automatic t_duty();
    int k;
    for (int d = 0; d < 4; d++) begin
      host.wr(CMD_PROX_CONF, {8'h03, d[1:0], 6'h10});
      k = n_meas;
      for (int j = 0; j < 1500 && n_meas < k + 2; j++) @(posedge ref_clk);
      if (n_meas < k + 2) begin
        n_mismatch++;
        break;
      end
      chk("period", 16'(per), 16'((40 << d) * DIV));
    end
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_regs();
    t_light_cfg();
    t_light_alert();
    t_prox();
    t_presence();
    t_forced();
    t_duty();
    results();
  end
endmodule // tb
`default_nettype wire
